// ---- logic/mstc_slave.sv ----
// Slave end: stall-paced or fixed-wait memory with pipelined reads.
//
// Design decisions made here: holding writes while reads are pending in variable mode, and overriding user stalls at the stall limit.
`timescale 1ns/10ps
module mstc_slave #(
    parameter bit          FIXED_MODE   = 1'b0,
    parameter int unsigned READ_WAIT    = mstc_pkg::DEF_READ_WAIT,
    parameter int unsigned WRITE_WAIT   = mstc_pkg::DEF_WRITE_WAIT,
    parameter int unsigned READ_LATENCY = mstc_pkg::DEF_READ_LATENCY
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    mstc_bus_if.dev                          bus,
    input  wire logic                        stall_req,
    input  wire logic                        ret_hold,
    output logic [mstc_pkg::PEND_W-1:0]      pend_count
);
    // Storage.
    logic [mstc_pkg::DATA_W-1:0] mem      [0:mstc_pkg::WORDS-1];
    logic [mstc_pkg::ADDR_W-1:0] q_addr   [0:mstc_pkg::MAX_PEND-1];
    logic [mstc_pkg::ADDR_W-1:0] lat_pipe [0:mstc_pkg::MAX_LAT-1];
    logic [mstc_pkg::ADDR_W-1:0] lat_tap  [0:mstc_pkg::MAX_LAT];
    logic [mstc_pkg::PTR_W-1:0]  q_wp;
    logic [mstc_pkg::PTR_W-1:0]  q_rp;
    logic [mstc_pkg::PEND_W-1:0] q_fill;
    logic [mstc_pkg::WAIT_W-1:0] wait_cnt;
    logic [mstc_pkg::RUN_W-1:0]  block_run;
    logic [mstc_pkg::DATA_W-1:0] ret_data;
    logic                        ret_valid;

    // Decode and selection.
    wire                        run_cap;
    wire                        stall_hold;
    wire                        pend_full;
    wire                        wr_blocked;
    wire                        var_wait;
    wire [mstc_pkg::WAIT_W-1:0] wait_need;
    wire                        fix_done;
    wire                        take_ok;
    wire                        rd_take;
    wire                        wr_take;
    wire                        push;
    wire                        pop;
    wire                        blocked;
    wire [mstc_pkg::DATA_W-1:0] fix_data;

    // Once the bus has been blocked for the limit, the user stall inputs are ignored for one cycle.
    assign run_cap    = block_run == mstc_pkg::STALL_LIMIT;
    assign stall_hold = stall_req & ~run_cap;
    assign pend_full  = pend_count == mstc_pkg::PEND_W'(mstc_pkg::MAX_PEND);
    // Returns read memory at the data phase, so a write would race pending reads.
    assign wr_blocked = bus.write & (pend_count != '0);
    assign var_wait   = stall_hold | pend_full | wr_blocked;

    assign wait_need  = bus.read ? mstc_pkg::WAIT_W'(READ_WAIT)
                                 : mstc_pkg::WAIT_W'(WRITE_WAIT);
    assign fix_done   = wait_cnt == wait_need;
    assign take_ok    = FIXED_MODE ? fix_done : ~var_wait;
    assign rd_take    = bus.read & take_ok;
    assign wr_take    = bus.write & take_ok;

    assign push       = rd_take & ~FIXED_MODE;
    // A pushed entry can only pop on a later edge, so data trails acceptance.
    assign pop        = ~FIXED_MODE & (q_fill != '0) & (~ret_hold | run_cap);
    assign blocked    = var_wait | ((q_fill != '0) & ~pop);

    // Fixed mode never stalls through the pin; variable mode stalls both ways.
    assign bus.waitrequest = ~FIXED_MODE & var_wait;

    assign lat_tap[0] = bus.address;
    for (genvar i = 0; i < mstc_pkg::MAX_LAT; i++) begin : g_tap
        assign lat_tap[i+1] = lat_pipe[i];
    end

    // With zero latency the word is read straight from the presented address.
    assign fix_data = mem[lat_tap[READ_LATENCY]];

    assign bus.readdata      = FIXED_MODE ? fix_data : ret_data;
    assign bus.readdatavalid = ret_valid;
    assign bus.response      = mstc_pkg::RESP_OKAY;

    // Memory writes take effect at the accepting edge, byte lane by byte lane.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int w = 0; w < mstc_pkg::WORDS; w++) begin
                mem[w] <= mstc_pkg::ZERO_WORD;
            end
        end else if (wr_take) begin
            for (int b = 0; b < mstc_pkg::BE_W; b++) begin
                if (bus.byteenable[b]) begin
                    mem[bus.address][b*mstc_pkg::BYTE_W +: mstc_pkg::BYTE_W] <=
                        bus.writedata[b*mstc_pkg::BYTE_W +: mstc_pkg::BYTE_W];
                end
            end
        end
    end

    // Fixed wait states count cycles of the held command.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= '0;
        end else if ((bus.read | bus.write) & ~take_ok) begin
            wait_cnt <= wait_cnt + mstc_pkg::WAIT_W'(1);
        end else begin
            wait_cnt <= '0;
        end
    end

    // Consecutive cycles in which the bus is stalled or returns are held.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_run <= '0;
        end else if (blocked & ~run_cap) begin
            block_run <= block_run + mstc_pkg::RUN_W'(1);
        end else begin
            block_run <= '0;
        end
    end

    // Address queue of accepted reads, drained strictly first in, first out.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_wp   <= '0;
            q_rp   <= '0;
            q_fill <= '0;
        end else begin
            if (push) begin
                q_addr[q_wp] <= bus.address;
                q_wp         <= q_wp + mstc_pkg::PTR_W'(1);
            end
            if (pop) begin
                q_rp <= q_rp + mstc_pkg::PTR_W'(1);
            end
            q_fill <= q_fill + mstc_pkg::PEND_W'(push) - mstc_pkg::PEND_W'(pop);
        end
    end

    // Returned word and its strobe; a read counts as pending until its strobe.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ret_valid  <= 1'b0;
            ret_data   <= mstc_pkg::ZERO_WORD;
            pend_count <= '0;
        end else begin
            ret_valid  <= pop;
            if (pop) begin
                ret_data <= mem[q_addr[q_rp]];
            end
            pend_count <= pend_count + mstc_pkg::PEND_W'(push)
                          - mstc_pkg::PEND_W'(ret_valid);
        end
    end

    // Address delay line for fixed latency; it shifts every cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < mstc_pkg::MAX_LAT; k++) begin
                lat_pipe[k] <= '0;
            end
        end else begin
            for (int k = 0; k < mstc_pkg::MAX_LAT; k++) begin
                lat_pipe[k] <= lat_tap[k];
            end
        end
    end
endmodule

// ---- common/mstc_pkg.sv ----
// Shared constants for the memory-mapped slave transfer control pair.
package mstc_pkg;
    // Bus shape.
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 32;
    localparam int BE_W     = 4;
    localparam int BYTE_W   = 8;
    localparam int WORDS    = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    // Pending-read bookkeeping.
    localparam int MAX_PEND = 4;
    localparam int PEND_W   = 3;
    localparam int PTR_W    = 2;

    // Fixed wait states run 0 to 1023 cycles; fixed read latency runs 0 to 64.
    localparam int WAIT_W           = 10;
    localparam int MAX_LAT          = 64;
    localparam int DEF_READ_WAIT    = 1;
    localparam int DEF_WRITE_WAIT   = 0;
    localparam int DEF_READ_LATENCY = 0;

    // Longest run of cycles that the slave-side user inputs may block the bus.
    localparam int RUN_W = 5;
    localparam logic [RUN_W-1:0] STALL_LIMIT = 5'h10;

    // APB register map of the requesting end.
    localparam int PADDR_W = 8;
    localparam logic [PADDR_W-1:0] OFS_CMD    = 8'h00;
    localparam logic [PADDR_W-1:0] OFS_WDATA  = 8'h04;
    localparam logic [PADDR_W-1:0] OFS_RDATA  = 8'h08;
    localparam logic [PADDR_W-1:0] OFS_STATUS = 8'h0C;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_ADDR_LSB  = 4;
    localparam int CMD_BE_LSB    = 8;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_PEND_LSB   = 4;
    localparam int ST_RET_LSB    = 8;
    localparam int RET_W         = 8;
endpackage

// ---- common/mstc_bus_if.sv ----
// Memory-mapped bus between the requesting end and the slave end.
`timescale 1ns/10ps
interface mstc_bus_if;
    logic [mstc_pkg::ADDR_W-1:0] address;
    logic [mstc_pkg::BE_W-1:0]   byteenable;
    logic                        read;
    logic                        write;
    logic [mstc_pkg::DATA_W-1:0] writedata;
    logic [mstc_pkg::DATA_W-1:0] readdata;
    logic [1:0]                  response;
    logic                        waitrequest;
    logic                        readdatavalid;

    modport dev (
        input  address,
        input  byteenable,
        input  read,
        input  write,
        input  writedata,
        output readdata,
        output response,
        output waitrequest,
        output readdatavalid
    );

    modport req (
        output address,
        output byteenable,
        output read,
        output write,
        output writedata,
        input  readdata,
        input  response,
        input  waitrequest,
        input  readdatavalid
    );
endinterface

// ---- logic/mstc_master.sv ----
// Requesting end: APB-programmed command issuer on the memory-mapped bus.
`timescale 1ns/10ps
module mstc_master #(
    parameter bit          FIXED_MODE   = 1'b0,
    parameter int unsigned READ_WAIT    = mstc_pkg::DEF_READ_WAIT,
    parameter int unsigned WRITE_WAIT   = mstc_pkg::DEF_WRITE_WAIT,
    parameter int unsigned READ_LATENCY = mstc_pkg::DEF_READ_LATENCY
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [mstc_pkg::PADDR_W-1:0] paddr,
    input  wire logic [mstc_pkg::DATA_W-1:0]  pwdata,
    output logic      [mstc_pkg::DATA_W-1:0]  prdata,
    output logic                              pready,
    output logic                              pslverr,
    mstc_bus_if.req                           bus
);
    logic                          req_rd;
    logic                          req_wr;
    logic [mstc_pkg::ADDR_W-1:0]   req_addr;
    logic [mstc_pkg::BE_W-1:0]     req_be;
    logic [mstc_pkg::DATA_W-1:0]   req_wdata;
    logic [mstc_pkg::DATA_W-1:0]   wdata_reg;
    logic [mstc_pkg::DATA_W-1:0]   rdata_reg;
    logic [mstc_pkg::RET_W-1:0]    ret_count;
    logic [mstc_pkg::PEND_W-1:0]   pend;
    logic [mstc_pkg::WAIT_W-1:0]   wait_cnt;
    logic [mstc_pkg::MAX_LAT-1:0]  lat_q;

    wire                           busy;
    wire                           hit_cmd;
    wire                           hit_wdata;
    wire                           hit_rdata;
    wire                           hit_status;
    wire                           apb_done;
    wire [mstc_pkg::WAIT_W-1:0]    wait_need;
    wire                           accept;
    wire                           rd_acc;
    wire [mstc_pkg::MAX_LAT:0]     lat_tap;
    wire                           capture;
    wire [mstc_pkg::DATA_W-1:0]    status_word;

    assign busy       = req_rd | req_wr;
    assign hit_cmd    = paddr == mstc_pkg::OFS_CMD;
    assign hit_wdata  = paddr == mstc_pkg::OFS_WDATA;
    assign hit_rdata  = paddr == mstc_pkg::OFS_RDATA;
    assign hit_status = paddr == mstc_pkg::OFS_STATUS;
    // A new command waits in the APB access phase while the last one is held.
    assign pready     = ~(psel & pwrite & hit_cmd & busy);
    assign apb_done   = psel & penable & pready;
    assign pslverr    = ~(hit_cmd | hit_wdata | hit_rdata | hit_status);

    assign wait_need  = req_rd ? mstc_pkg::WAIT_W'(READ_WAIT)
                               : mstc_pkg::WAIT_W'(WRITE_WAIT);
    // Requests are raised regardless of waitrequest and held until taken.
    assign accept     = busy & (FIXED_MODE ? (wait_cnt == wait_need) : ~bus.waitrequest);
    assign rd_acc     = accept & req_rd;
    assign lat_tap    = {lat_q, rd_acc};
    assign capture    = FIXED_MODE ? lat_tap[READ_LATENCY] : bus.readdatavalid;

    assign bus.address    = req_addr;
    assign bus.byteenable = req_be;
    assign bus.read       = req_rd;
    assign bus.write      = req_wr;
    assign bus.writedata  = req_wdata;

    assign status_word = mstc_pkg::ZERO_WORD
                         | (mstc_pkg::DATA_W'(busy) << mstc_pkg::ST_BUSY_BIT)
                         | (mstc_pkg::DATA_W'(pend) << mstc_pkg::ST_PEND_LSB)
                         | (mstc_pkg::DATA_W'(ret_count) << mstc_pkg::ST_RET_LSB);

    always_comb begin
        if (hit_cmd) begin
            prdata = mstc_pkg::DATA_W'({req_be, req_addr, 3'h0, req_wr});
        end else if (hit_wdata) begin
            prdata = wdata_reg;
        end else if (hit_rdata) begin
            prdata = rdata_reg;
        end else if (hit_status) begin
            prdata = status_word;
        end else begin
            prdata = mstc_pkg::ZERO_WORD;
        end
    end

    // Command launch and hold.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_rd    <= 1'b0;
            req_wr    <= 1'b0;
            req_addr  <= '0;
            req_be    <= '0;
            req_wdata <= mstc_pkg::ZERO_WORD;
            wdata_reg <= mstc_pkg::ZERO_WORD;
        end else begin
            if (apb_done & pwrite & hit_wdata) begin
                wdata_reg <= pwdata;
            end
            if (apb_done & pwrite & hit_cmd) begin
                req_wr    <= pwdata[mstc_pkg::CMD_WRITE_BIT];
                req_rd    <= ~pwdata[mstc_pkg::CMD_WRITE_BIT];
                req_addr  <= pwdata[mstc_pkg::CMD_ADDR_LSB +: mstc_pkg::ADDR_W];
                req_be    <= pwdata[mstc_pkg::CMD_BE_LSB +: mstc_pkg::BE_W];
                req_wdata <= wdata_reg;
            end else if (accept) begin
                req_rd <= 1'b0;
                req_wr <= 1'b0;
            end
        end
    end

    // Wait-state count, latency tracking and returned data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt  <= '0;
            lat_q     <= '0;
            pend      <= '0;
            ret_count <= '0;
            rdata_reg <= mstc_pkg::ZERO_WORD;
        end else begin
            wait_cnt <= (busy & ~accept) ? wait_cnt + mstc_pkg::WAIT_W'(1) : '0;
            lat_q    <= lat_tap[mstc_pkg::MAX_LAT-1:0];
            pend     <= pend + mstc_pkg::PEND_W'(rd_acc) - mstc_pkg::PEND_W'(capture);
            if (capture) begin
                rdata_reg <= bus.readdata;
                ret_count <= ret_count + mstc_pkg::RET_W'(1);
            end
        end
    end
endmodule

// ---- verif/mstc_bus_assertions.sv ----
// Checker for the memory-mapped bus between the requesting end and the slave end.
`timescale 1ns/10ps
module mstc_bus_assertions (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic [mstc_pkg::ADDR_W-1:0] address,
    input wire logic [mstc_pkg::BE_W-1:0]   byteenable,
    input wire logic                        read,
    input wire logic                        write,
    input wire logic [mstc_pkg::DATA_W-1:0] writedata,
    input wire logic [mstc_pkg::DATA_W-1:0] readdata,
    input wire logic [1:0]                  response,
    input wire logic                        waitrequest,
    input wire logic                        readdatavalid
);
    // Reads accepted on the bus and not yet returned, seen from the wires only.
    logic [3:0] pend;
    logic [6:0] wait_run;
    wire logic [3:0] next_pend = pend + {3'h0, read && !waitrequest} - {3'h0, readdatavalid};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend     <= 4'h0;
            wait_run <= 7'h00;
        end else begin
            pend     <= next_pend;
            wait_run <= waitrequest ? wait_run + 7'h01 : 7'h00;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_READ_HOLD: assert property (read && waitrequest |=>
        read && $stable(address) && $stable(byteenable)) else $error("read request moved while stalled");
    AST_WRITE_HOLD: assert property (write && waitrequest |=>
        write && $stable(writedata) && $stable(address)) else $error("write request moved while stalled");
    AST_NO_WRITE_WITH_PEND: assert property (write && !waitrequest |-> pend == 4'h0)
        else $error("write accepted while reads pending");
    AST_PEND_CAP: assert property (pend <= mstc_pkg::MAX_PEND)
        else $error("pending reads above maximum");
    AST_RDV_AFTER_ACCEPT: assert property (readdatavalid |-> pend != 4'h0)
        else $error("read data returned with no read accepted earlier");
    AST_WAIT_BOUNDED: assert property (wait_run < 7'h64)
        else $error("waitrequest held too long");
    AST_RESP_OKAY: assert property (readdatavalid |-> response == mstc_pkg::RESP_OKAY)
        else $error("bad response with read data");
    AST_RESET_QUIET: assert property ($rose(presetn) |-> !readdatavalid && !read && !write)
        else $error("bus not idle after reset");

    cover property (read && waitrequest ##[1:20] read && !waitrequest);
    cover property (pend == 4'h4);
    cover property (write && !waitrequest);
    cover property (readdatavalid && waitrequest);
endmodule

// ---- verif/tb.sv ----
// Testbench joining the requesting end and the slave end, driven over APB.
`timescale 1ns/10ps
module tb;
    logic                         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic                         stall_req, ret_hold, hold_mode, err;
    logic [mstc_pkg::PADDR_W-1:0] paddr;
    logic [mstc_pkg::DATA_W-1:0]  pwdata, prdata, rd, last_word;
    logic [mstc_pkg::PEND_W-1:0]  pend_count;
    logic [31:0]                  seed;
    logic [7:0]                   n_ret;
    logic [31:0]                  mem [mstc_pkg::WORDS];
    logic [31:0]                  exp_q [$];
    int                           failures, n_compared, n_fw, n_fr;
    logic                         fx, pready_f, pslverr_f;
    logic [mstc_pkg::DATA_W-1:0]  prdata_f, last_cmd, r_f;
    logic [mstc_pkg::PEND_W-1:0]  pend_f;
    logic [31:0]                  fmem [mstc_pkg::WORDS];
    wire                          psel_v = psel & ~fx;
    wire                          psel_f = psel & fx;
    wire                          pready_m = fx ? pready_f : pready;
    wire                          pslverr_m = fx ? pslverr_f : pslverr;
    wire  [mstc_pkg::DATA_W-1:0]  prdata_m = fx ? prdata_f : prdata;

    mstc_bus_if bus ();
    mstc_master i_mstc_master (.pclk(pclk), .presetn(presetn), .psel(psel_v), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus));
    mstc_slave i_mstc_slave (.pclk(pclk), .presetn(presetn), .bus(bus), .stall_req(stall_req),
        .ret_hold(ret_hold), .pend_count(pend_count));
    // A second pair runs with fixed wait states so that mode is exercised too.
    mstc_bus_if bus_f ();
    mstc_master #(.FIXED_MODE(1'b1), .READ_WAIT(32'h0000_0001), .WRITE_WAIT(32'h0000_0002))
        i_mstc_master_fixed (.pclk(pclk), .presetn(presetn), .psel(psel_f), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_f), .pready(pready_f),
        .pslverr(pslverr_f), .bus(bus_f));
    mstc_slave #(.FIXED_MODE(1'b1), .READ_WAIT(32'h0000_0001), .WRITE_WAIT(32'h0000_0002))
        i_mstc_slave_fixed (.pclk(pclk), .presetn(presetn), .bus(bus_f), .stall_req(stall_req),
        .ret_hold(ret_hold), .pend_count(pend_f));
    mstc_bus_assertions i_mstc_bus_assertions (.pclk(pclk), .presetn(presetn),
        .address(bus.address), .byteenable(bus.byteenable), .read(bus.read), .write(bus.write),
        .writedata(bus.writedata), .readdata(bus.readdata), .response(bus.response),
        .waitrequest(bus.waitrequest), .readdatavalid(bus.readdatavalid));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // Word left in memory after a lane-masked write.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            if (be[b]) old[b*8 +: 8] = d[b*8 +: 8];
        end
        return old;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            failures++;
            $display("BAD %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic end_of_test();
        $display("failures=%0d n_compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_m !== 1'b1);
        rd = prdata_m;
        err = pslverr_m;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic issue(input logic wr_op, input logic [31:0] r);
        if (wr_op) begin
            apb(1'b1, mstc_pkg::OFS_WDATA, xs(r));
        end
        last_cmd = {20'h0_0000, r[11:8], r[7:4], 3'h0, wr_op};
        apb(1'b1, mstc_pkg::OFS_CMD, last_cmd);
    endtask

    // Waits until nothing is in flight; the watchdog bounds a hang here.
    task automatic drain();
        do apb(1'b0, mstc_pkg::OFS_STATUS, 32'h0000_0000);
        while (rd[mstc_pkg::ST_BUSY_BIT] !== 1'b0 || rd[mstc_pkg::ST_PEND_LSB +: 3] !== 3'h0);
    endtask

    // Random stalls and held returns change every cycle; hold mode pins returns back.
    always @(posedge pclk) begin
        seed      <= xs(seed);
        stall_req <= !hold_mode && (seed[1:0] == 2'h0);
        ret_hold  <= hold_mode || seed[2];
    end

    // Bus monitor: a memory image and the queue of words owed, in acceptance order.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exp_q.delete();
            foreach (mem[i]) mem[i] = 32'h0000_0000;
            n_ret = 8'h00;
            last_word = 32'h0000_0000;
            n_fw = 0;
            n_fr = 0;
        end else begin
            if (bus.readdatavalid) begin
                n_ret = n_ret + 8'h01;
                last_word = bus.readdata;
                if (exp_q.size() != 0) begin
                    chk(bus.readdata, exp_q.pop_front());
                end else begin
                    n_compared++;
                    failures++;
                    $display("BAD %0t: returned word with no read owed", $time);
                end
            end
            if (bus_f.write) n_fw++;
            if (bus_f.read) n_fr++;
            if (bus.read && !bus.waitrequest) exp_q.push_back(mem[bus.address]);
            if (bus.write && !bus.waitrequest) begin
                for (int b = 0; b < mstc_pkg::BE_W; b++)
                    if (bus.byteenable[b]) mem[bus.address][b*8 +: 8] = bus.writedata[b*8 +: 8];
            end
        end
    end

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        repeat (40000) @(posedge pclk);
        failures++;
        $display("BAD %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        stall_req = 1'b0;
        ret_hold = 1'b0;
        hold_mode = 1'b0;
        fx = 1'b0;
        foreach (fmem[i]) fmem[i] = 32'h0000_0000;
        seed = 32'h0000_0059;
        failures = 0;
        n_compared = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, mstc_pkg::OFS_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001);
        for (int i = 0; i < 40; i++) issue(seed[3], seed);
        hold_mode <= 1'b1;
        for (int i = 0; i < 6; i++) issue(1'b0, seed);
        hold_mode <= 1'b0;
        issue(1'b1, seed);
        issue(1'b0, seed);
        drain();
        chk({24'h00_0000, rd[mstc_pkg::ST_RET_LSB +: 8]}, {24'h00_0000, n_ret});
        chk({29'h0000_0000, pend_count}, 32'h0000_0000);
        apb(1'b0, mstc_pkg::OFS_RDATA, 32'h0000_0000);
        chk(rd, last_word);
        fx <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            r_f = seed;
            fmem[r_f[7:4]] = merge(fmem[r_f[7:4]], xs(r_f), r_f[11:8]);
            issue(1'b1, r_f);
            issue(1'b0, r_f);
            drain();
            apb(1'b0, mstc_pkg::OFS_RDATA, 32'h0000_0000);
            chk(rd, fmem[r_f[7:4]]);
        end
        apb(1'b0, mstc_pkg::OFS_CMD, 32'h0000_0000);
        chk(rd, last_cmd);
        chk(n_fw, 32'h0000_0018);
        chk(n_fr, 32'h0000_0010);
        chk({29'h0000_0000, pend_f}, 32'h0000_0000);
        fx <= 1'b0;
        hold_mode <= 1'b1;
        issue(1'b0, seed);
        issue(1'b0, seed);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        hold_mode <= 1'b0;
        apb(1'b0, mstc_pkg::OFS_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, mstc_pkg::OFS_RDATA, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        end_of_test();
    end
endmodule
